// file: rtl/pstu_pkg.sv
/*
 package for the precision time update / target block: register offsets,
 field positions, reset values and the subsecond unit.
 assumes a 32-bit register port with byte addresses.
*/
package pstu_pkg;
   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [11:0] OFF_SUBSEC_LIVE = 12'h070c; // live low time word, read only
   localparam logic [11:0] OFF_UPD_SECONDS = 12'h0710; // staged seconds
   localparam logic [11:0] OFF_UPD_SUBSEC = 12'h0714; // staged sign and subseconds
   localparam logic [11:0] OFF_ADDEND = 12'h0718; // fine correction addend
   localparam logic [11:0] OFF_TARGET_SEC = 12'h071c; // target seconds
   localparam logic [11:0] OFF_TARGET_LOW = 12'h0720; // target low word
   localparam logic [11:0] OFF_CONTROL = 12'h0740; // command and mode bits
   localparam logic [11:0] OFF_INCREMENT = 12'h0744; // subsecond increment
   localparam logic [11:0] OFF_SECONDS_LIVE = 12'h0748; // live seconds, read only
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h0750; // sticky events, read only
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h0754; // event enables
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h0758; // write one to clear, write only
   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int SIGN_BIT = 31; // sign flag of a low time word
   localparam int SUBSEC_W = 31; // subsecond field width
   localparam int CTL_FINE = 1; // fine_mode_select
   localparam int CTL_INIT = 2; // init_time_cmd
   localparam int CTL_UPDATE = 3; // update_time_cmd
   localparam int CTL_TGT_EN = 4; // target_irq_enable
   localparam int CTL_ADD_UPD = 5; // addend_update_cmd
   localparam int CTL_W = 6; // control bits in use
   localparam int INC_W = 8; // subsec_increment width
   localparam int IRQ_TARGET = 0; // target time reached event
   localparam int IRQ_W = 1; // event count
   // ------------------------------------------------------------------
   // reset values and units
   // ------------------------------------------------------------------
   localparam logic [31:0] RESET_WORD = 32'h0000_0000; // all registers reset to zero
   localparam real SUBSEC_UNIT_NS = 0.46; // one subsecond count
endpackage : pstu_pkg

// file: rtl/pstu_time_unit.sv
/*
 system time keeper with staged init/update, fine addend accumulator and
 target time compare with interrupt.
 assumes a simple register port (read data one cycle after the read strobe)
 and one 25 MHz clock with synchronous active-high reset.
*/
// The implementer's own choice: the plain strobed port.
//
// Operation
// - live low word: sign bit, 31-bit subseconds
// - one subsecond count is about 0.46 ns
// - live sign normally reads zero
// - writable 32-bit staged seconds word
// - staged low word: sign plus subseconds
// - update subtracts when sign set, else adds
// - addend used only in fine mode
// - fine mode: accumulate addend, tick on overflow
// - writable target seconds and target low words
// - time reaching target raises enabled interrupt
// - increment per cycle coarse, per overflow fine
// - init and update commands self-clear when done
// - target enable clears when the target event is set, masked or not
// - addend update loads addend, then self-clears
`timescale 1ns/1ps
module pstu_time_unit #(
   parameter int ADDR_W = 12 // register address width
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [31:0] reg_rdata_o,
   // interrupt
   output logic irq_o
);
   // ------------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------------
   if (ADDR_W < 12) begin : g_bad_addr
      $error("ADDR_W must be at least 12");
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [31:0] sec_q; // live seconds
   logic [30:0] sub_q; // live subseconds
   logic neg_q; // live sign
   logic [31:0] upd_sec_q; // staged seconds
   logic [31:0] upd_sub_q; // staged sign and subseconds
   logic [31:0] addend_q; // software addend
   logic [31:0] addend_used_q; // addend in the fine logic
   logic [31:0] acc_q; // fine accumulator
   logic [31:0] tgt_sec_q; // target seconds
   logic [31:0] tgt_low_q; // target low word
   logic [pstu_pkg::CTL_W-1:0] ctl_q; // control bits
   logic [pstu_pkg::INC_W-1:0] inc_q; // subsecond increment
   logic [pstu_pkg::IRQ_W-1:0] sts_q; // sticky events
   logic [pstu_pkg::IRQ_W-1:0] ien_q; // event enables
   logic [31:0] rdata_q; // read data
   logic irq_q; // interrupt output

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   wire logic [11:0] a = reg_addr_i[11:0];
   // upper address bits, when there are any, must be zero for a hit
   wire logic hit_hi;
   if (ADDR_W > 12) begin : g_hi_addr
      assign hit_hi = (reg_addr_i[ADDR_W-1:12] == '0);
   end else begin : g_no_hi_addr
      assign hit_hi = 1'b1;
   end
   wire logic wr_usec = reg_write_i && hit_hi && a == pstu_pkg::OFF_UPD_SECONDS;
   wire logic wr_usub = reg_write_i && hit_hi && a == pstu_pkg::OFF_UPD_SUBSEC;
   wire logic wr_add = reg_write_i && hit_hi && a == pstu_pkg::OFF_ADDEND;
   wire logic wr_tsec = reg_write_i && hit_hi && a == pstu_pkg::OFF_TARGET_SEC;
   wire logic wr_tlow = reg_write_i && hit_hi && a == pstu_pkg::OFF_TARGET_LOW;
   wire logic wr_ctl = reg_write_i && hit_hi && a == pstu_pkg::OFF_CONTROL;
   wire logic wr_inc = reg_write_i && hit_hi && a == pstu_pkg::OFF_INCREMENT;
   wire logic wr_ien = reg_write_i && hit_hi && a == pstu_pkg::OFF_IRQ_ENABLE;
   wire logic wr_clr = reg_write_i && hit_hi && a == pstu_pkg::OFF_IRQ_CLEAR;

   // ------------------------------------------------------------------
   // command bits
   // ------------------------------------------------------------------
   wire logic init_cmd = ctl_q[pstu_pkg::CTL_INIT];
   wire logic upd_cmd = ctl_q[pstu_pkg::CTL_UPDATE];
   wire logic fine = ctl_q[pstu_pkg::CTL_FINE];
   wire logic tgt_en = ctl_q[pstu_pkg::CTL_TGT_EN];
   wire logic add_cmd = ctl_q[pstu_pkg::CTL_ADD_UPD];

   // ------------------------------------------------------------------
   // time advance
   // ------------------------------------------------------------------
   // fine accumulator: the carry out of the 33-bit sum is the tick
   wire logic [32:0] acc_sum = {1'b0, acc_q} + {1'b0, addend_used_q};
   wire logic tick = fine ? acc_sum[32] : 1'b1;
   // one increment of the subseconds, carrying into seconds on overflow
   wire logic [31:0] inc_sum = {1'b0, sub_q} + {24'h00_0000, inc_q};
   wire logic [31:0] inc_sec = sec_q + {31'h0000_0000, inc_sum[31]};
   // staged update: add or subtract, with carry or borrow
   wire logic [31:0] add_sub = {1'b0, sub_q} + {1'b0, upd_sub_q[30:0]};
   wire logic [31:0] dif_sub = {1'b0, sub_q} - {1'b0, upd_sub_q[30:0]};
   wire logic [31:0] add_sec = sec_q + upd_sec_q + {31'h0000_0000, add_sub[31]};
   wire logic [31:0] dif_sec = sec_q - upd_sec_q - {31'h0000_0000, dif_sub[31]};
   wire logic subtract = upd_sub_q[pstu_pkg::SIGN_BIT];

   // ------------------------------------------------------------------
   // target compare: equal or past
   // ------------------------------------------------------------------
   wire logic reached = !neg_q && ((sec_q > tgt_sec_q) ||
                        (sec_q == tgt_sec_q && {1'b0, sub_q} >= tgt_low_q));
   wire logic fire = tgt_en && reached;

   // ------------------------------------------------------------------
   // system time
   // ------------------------------------------------------------------
   // init and update take priority over the running increment in that cycle;
   // one write updates seconds and subseconds together so no read sees half
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sec_q <= 32'h0000_0000;
         sub_q <= 31'h0000_0000;
         neg_q <= 1'b0;
      end else if (init_cmd) begin
         sec_q <= upd_sec_q;
         sub_q <= upd_sub_q[30:0];
         neg_q <= upd_sub_q[pstu_pkg::SIGN_BIT];
      end else if (upd_cmd) begin
         sec_q <= subtract ? dif_sec : add_sec;
         sub_q <= subtract ? dif_sub[30:0] : add_sub[30:0];
      end else if (tick) begin
         sec_q <= inc_sec;
         sub_q <= inc_sum[30:0];
      end
   end

   // ------------------------------------------------------------------
   // accumulator and addend transfer
   // ------------------------------------------------------------------
   // the accumulator only runs in fine mode, so coarse mode ignores the addend
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         acc_q <= 32'h0000_0000;
         addend_used_q <= 32'h0000_0000;
      end else begin
         if (fine) begin
            acc_q <= acc_sum[31:0];
         end
         if (add_cmd) begin
            addend_used_q <= addend_q;
         end
      end
   end

   // ------------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         upd_sec_q <= pstu_pkg::RESET_WORD;
         upd_sub_q <= pstu_pkg::RESET_WORD;
         addend_q <= pstu_pkg::RESET_WORD;
         tgt_sec_q <= pstu_pkg::RESET_WORD;
         tgt_low_q <= pstu_pkg::RESET_WORD;
         inc_q <= 8'h00;
         ien_q <= '0;
      end else begin
         if (wr_usec) upd_sec_q <= reg_wdata_i;
         if (wr_usub) upd_sub_q <= reg_wdata_i;
         if (wr_add) addend_q <= reg_wdata_i;
         if (wr_tsec) tgt_sec_q <= reg_wdata_i;
         if (wr_tlow) tgt_low_q <= reg_wdata_i;
         if (wr_inc) inc_q <= reg_wdata_i[pstu_pkg::INC_W-1:0];
         if (wr_ien) ien_q <= reg_wdata_i[pstu_pkg::IRQ_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // control bits
   // ------------------------------------------------------------------
   // commands complete in the one cycle they are seen, then clear; a write
   // landing while a command bit is still set cannot re-arm it, since the
   // hardware clear in that cycle wins for commands already running
   logic [pstu_pkg::CTL_W-1:0] ctl_d;
   always_comb begin
      ctl_d = wr_ctl ? reg_wdata_i[pstu_pkg::CTL_W-1:0] : ctl_q;
      ctl_d[0] = 1'b0; // enable bit of frame stamping lives elsewhere
      if (init_cmd) ctl_d[pstu_pkg::CTL_INIT] = 1'b0;
      if (upd_cmd) ctl_d[pstu_pkg::CTL_UPDATE] = 1'b0;
      if (add_cmd) ctl_d[pstu_pkg::CTL_ADD_UPD] = 1'b0;
      if (fire) ctl_d[pstu_pkg::CTL_TGT_EN] = 1'b0;
   end
   always_ff @(posedge clock_i) begin
      if (reset_i) ctl_q <= '0;
      else ctl_q <= ctl_d;
   end

   // ------------------------------------------------------------------
   // interrupt status: set wins over clear
   // ------------------------------------------------------------------
   wire logic [pstu_pkg::IRQ_W-1:0] ev = fire ? 1'b1 : 1'b0;
   wire logic [pstu_pkg::IRQ_W-1:0] clr = wr_clr ? reg_wdata_i[pstu_pkg::IRQ_W-1:0] : '0;
   // next enable word, so the level follows an enable write in step with the status
   wire logic [pstu_pkg::IRQ_W-1:0] ien_nx = wr_ien ? reg_wdata_i[pstu_pkg::IRQ_W-1:0] : ien_q;
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sts_q <= '0;
         irq_q <= 1'b0;
      end else begin
         sts_q <= (sts_q & ~clr) | ev;
         irq_q <= |(((sts_q & ~clr) | ev) & ien_nx);
      end
   end
   assign irq_o = irq_q;

   // ------------------------------------------------------------------
   // read mux, data in the cycle after the strobe
   // ------------------------------------------------------------------
   logic [31:0] rsel;
   always_comb begin
      unique case (a)
         pstu_pkg::OFF_SUBSEC_LIVE: rsel = {neg_q, sub_q};
         pstu_pkg::OFF_UPD_SECONDS: rsel = upd_sec_q;
         pstu_pkg::OFF_UPD_SUBSEC: rsel = upd_sub_q;
         pstu_pkg::OFF_ADDEND: rsel = addend_q;
         pstu_pkg::OFF_TARGET_SEC: rsel = tgt_sec_q;
         pstu_pkg::OFF_TARGET_LOW: rsel = tgt_low_q;
         pstu_pkg::OFF_CONTROL: rsel = {26'h000_0000, ctl_q};
         pstu_pkg::OFF_INCREMENT: rsel = {24'h00_0000, inc_q};
         pstu_pkg::OFF_SECONDS_LIVE: rsel = sec_q;
         pstu_pkg::OFF_IRQ_STATUS: rsel = {31'h0000_0000, sts_q};
         pstu_pkg::OFF_IRQ_ENABLE: rsel = {31'h0000_0000, ien_q};
         default: rsel = 32'h0000_0000; // unmapped and write-only read zero
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (reset_i) rdata_q <= 32'h0000_0000;
      else if (reg_read_i) rdata_q <= hit_hi ? rsel : 32'h0000_0000;
      else rdata_q <= 32'h0000_0000;
   end
   assign reg_rdata_o = rdata_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   // update and fine-tick time arithmetic is restated as one 63-bit number, so a slip in those split
   // carry and borrow adders cannot hide behind a copy of themselves
   init_load_a: assert property (@(posedge clock_i) disable iff (reset_i)
      init_cmd |=> sec_q == $past(upd_sec_q) && sub_q == $past(upd_sub_q[30:0]))
      else $error("init did not load staged time");
   init_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
      init_cmd |=> !init_cmd)
      else $error("init command did not self clear");
   upd_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
      upd_cmd |=> !upd_cmd)
      else $error("update command did not self clear");
   upd_add_a: assert property (@(posedge clock_i) disable iff (reset_i)
      upd_cmd && !init_cmd && !subtract |=> {sec_q, sub_q} == $past({sec_q, sub_q}) + $past({upd_sec_q, upd_sub_q[30:0]}))
      else $error("update did not add staged time");
   upd_sub_a: assert property (@(posedge clock_i) disable iff (reset_i)
      upd_cmd && !init_cmd && subtract |=> {sec_q, sub_q} == $past({sec_q, sub_q}) - $past({upd_sec_q, upd_sub_q[30:0]}))
      else $error("update did not subtract staged time");
   tgt_en_clear_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fire |=> !tgt_en && sts_q[pstu_pkg::IRQ_TARGET])
      else $error("target fire did not clear enable or set status");
   tgt_fire_a: assert property (@(posedge clock_i) disable iff (reset_i)
      tgt_en && !neg_q && {sec_q, 1'b0, sub_q} >= {tgt_sec_q, tgt_low_q} |=> sts_q[pstu_pkg::IRQ_TARGET] && !tgt_en)
      else $error("target reached without event");
   tgt_quiet_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !tgt_en && !sts_q[pstu_pkg::IRQ_TARGET] |=> !sts_q[pstu_pkg::IRQ_TARGET])
      else $error("target event without enable");
   coarse_tick_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !fine && !init_cmd && !upd_cmd |=> sub_q == $past(inc_sum[30:0]))
      else $error("coarse mode did not increment");
   fine_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fine && !acc_sum[32] && !init_cmd && !upd_cmd |=> $stable(sub_q) && $stable(sec_q))
      else $error("fine mode advanced without overflow");
   fine_tick_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fine && (acc_q + addend_used_q) < acc_q && !init_cmd && !upd_cmd |=>
      {sec_q, sub_q} == $past({sec_q, sub_q}) + $past(inc_q))
      else $error("fine mode overflow did not advance time");
   addend_load_a: assert property (@(posedge clock_i) disable iff (reset_i)
      add_cmd |=> addend_used_q == $past(addend_q) && !add_cmd)
      else $error("addend transfer failed");
   irq_level_a: assert property (@(posedge clock_i) disable iff (reset_i)
      irq_o == |(sts_q & ien_q))
      else $error("interrupt level wrong");
   live_sign_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !init_cmd |=> $stable(neg_q))
      else $error("live sign changed without init");
   coarse_acc_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !fine |=> $stable(acc_q))
      else $error("accumulator moved in coarse mode");
endmodule : pstu_time_unit

// file: dv/tb_top.sv
/*
 self-checking bench for the time update / target block: register readback,
 init and add/subtract updates, coarse and fine advance, target interrupt.
 assumes pstu_pkg is compiled first and the block answers reads one cycle late.
*/
`timescale 1ns/1ps
module tb_top;
   // ------------------------------------------------------------------
   // signals and bench state
   // ------------------------------------------------------------------
   logic clock_i = 1'b0; // 25 MHz bench clock
   logic reset_i = 1'b1; // synchronous reset, held at start
   logic [11:0] reg_addr_i = 12'h0000; // register address
   logic [31:0] reg_wdata_i = 32'h0000_0000; // write data
   logic reg_write_i = 1'b0; // write strobe
   logic reg_read_i = 1'b0; // read strobe
   logic [31:0] reg_rdata_o; // read data, one cycle after strobe
   logic irq_o; // interrupt level
   int err_count = 0; // mismatches seen
   int n_tests = 0; // comparisons made
   int cyc = 0; // cycle count for the hang guard
   logic [31:0] lfsr_q = 32'h0001_8380; // random source, fixed start
   logic [31:0] mdl_sec = 32'h0000_0000; // model seconds
   logic [30:0] mdl_sub = 31'h0000_0000; // model subseconds
   logic [11:0] offs [8] = '{pstu_pkg::OFF_SUBSEC_LIVE, pstu_pkg::OFF_UPD_SECONDS, pstu_pkg::OFF_UPD_SUBSEC,
      pstu_pkg::OFF_ADDEND, pstu_pkg::OFF_TARGET_SEC, pstu_pkg::OFF_TARGET_LOW, pstu_pkg::OFF_CONTROL,
      pstu_pkg::OFF_IRQ_STATUS}; // registers whose reset value is zero

   pstu_time_unit #(.ADDR_W(12)) uut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

   // ------------------------------------------------------------------
   // clock and hang guard
   // ------------------------------------------------------------------
   always #20 clock_i = ~clock_i;
   // whole run needs well under a thousand cycles; the ceiling leaves a wide margin
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   task automatic conclude();
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one-cycle write strobe, held until the edge that takes it
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
   endtask : wr

   // data is looked at only in the single cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask : rd

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk($sformatf("reg_%h", a), exp, v);
      // read data stands for one cycle only, then returns to zero
      @(posedge clock_i);
      #1 chk("rdata_idle", 32'h0000_0000, reg_rdata_o);
   endtask : rchk

   // stage a time, issue init or update, then compare live time with the model
   task automatic timeop(input logic [31:0] cmd, input logic sgn, input logic [31:0] s, input logic [30:0] ss);
      logic [62:0] t;
      t = {mdl_sec, mdl_sub};
      if (cmd == 32'h0000_0004) t = {s, ss};
      else if (sgn) t = t - {s, ss};
      else t = t + {s, ss};
      mdl_sec = t[62:31];
      mdl_sub = t[30:0];
      wr(pstu_pkg::OFF_UPD_SECONDS, s);
      wr(pstu_pkg::OFF_UPD_SUBSEC, {sgn, ss});
      wr(pstu_pkg::OFF_CONTROL, cmd);
      repeat (3) @(posedge clock_i);
      rchk(pstu_pkg::OFF_CONTROL, 32'h0000_0000);
      rchk(pstu_pkg::OFF_SUBSEC_LIVE, {1'b0, mdl_sub});
      rchk(pstu_pkg::OFF_SECONDS_LIVE, mdl_sec);
   endtask : timeop

   // advance of the live subseconds between two reads 2+idle edges apart
   task automatic drift(input int idle, input logic [31:0] exp);
      logic [31:0] a;
      logic [31:0] b;
      rd(pstu_pkg::OFF_SUBSEC_LIVE, a);
      repeat (idle) @(posedge clock_i);
      rd(pstu_pkg::OFF_SUBSEC_LIVE, b);
      chk("drift", exp, b - a);
   endtask : drift

   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clock_i);
      #1 chk("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq_o});
   endtask : irq_is

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      foreach (offs[i]) rchk(offs[i], 32'h0000_0000);
      // random readback of the staged, addend and target words; addend is not applied here
      for (int i = 1; i < 6; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         wr(offs[i], lfsr_q);
         rchk(offs[i], lfsr_q);
      end
      lfsr_q = lfsr_next(lfsr_q);
      wr(pstu_pkg::OFF_SUBSEC_LIVE, lfsr_q);
      rchk(pstu_pkg::OFF_SUBSEC_LIVE, 32'h0000_0000);
      wr(12'h07fc, lfsr_q);
      rchk(12'h07fc, 32'h0000_0000);
      rchk(pstu_pkg::OFF_IRQ_CLEAR, 32'h0000_0000);
      // init near the wrap, then add, subtract and add across the carry
      timeop(32'h0000_0004, 1'b0, 32'h0000_0005, 31'h7fff_fff0);
      timeop(32'h0000_0008, 1'b0, 32'h0000_0001, 31'h0000_0020);
      timeop(32'h0000_0008, 1'b1, 32'h0000_0001, 31'h0000_0020);
      timeop(32'h0000_0008, 1'b0, 32'h0000_0001, 31'h0000_0020);
      // coarse and fine advance, checked by differences so phase does not matter
      lfsr_q = lfsr_next(lfsr_q);
      wr(pstu_pkg::OFF_INCREMENT, lfsr_q);
      rchk(pstu_pkg::OFF_INCREMENT, {24'h00_0000, lfsr_q[7:0]});
      wr(pstu_pkg::OFF_INCREMENT, 32'h0000_0003);
      rchk(pstu_pkg::OFF_INCREMENT, 32'h0000_0003);
      drift(0, 32'h0000_0006);
      wr(pstu_pkg::OFF_CONTROL, 32'h0000_0002);
      drift(2, 32'h0000_0000);
      wr(pstu_pkg::OFF_ADDEND, 32'h4000_0000);
      wr(pstu_pkg::OFF_CONTROL, 32'h0000_0022);
      repeat (2) @(posedge clock_i);
      rchk(pstu_pkg::OFF_CONTROL, 32'h0000_0002);
      drift(2, 32'h0000_0003);
      drift(6, 32'h0000_0006);
      wr(pstu_pkg::OFF_CONTROL, 32'h0000_0000);
      drift(0, 32'h0000_0006);
      // target just ahead of a frozen time, then let it run into it
      wr(pstu_pkg::OFF_INCREMENT, 32'h0000_0000);
      timeop(32'h0000_0004, 1'b0, 32'h0000_0007, 31'h0000_0010);
      wr(pstu_pkg::OFF_TARGET_SEC, 32'h0000_0007);
      wr(pstu_pkg::OFF_TARGET_LOW, 32'h0000_0011);
      wr(pstu_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
      rchk(pstu_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
      wr(pstu_pkg::OFF_CONTROL, 32'h0000_0010);
      irq_is(1'b0);
      rchk(pstu_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
      rchk(pstu_pkg::OFF_CONTROL, 32'h0000_0010);
      wr(pstu_pkg::OFF_INCREMENT, 32'h0000_0001);
      irq_is(1'b1);
      rchk(pstu_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
      rchk(pstu_pkg::OFF_CONTROL, 32'h0000_0000);
      wr(pstu_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
      irq_is(1'b0);
      rchk(pstu_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
      // masked event: seconds already past, low word above live subseconds
      wr(pstu_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
      wr(pstu_pkg::OFF_TARGET_SEC, 32'h0000_0006);
      wr(pstu_pkg::OFF_TARGET_LOW, 32'hffff_ffff);
      wr(pstu_pkg::OFF_CONTROL, 32'h0000_0010);
      irq_is(1'b0);
      rchk(pstu_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
      wr(pstu_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
      irq_is(1'b1);
      wr(pstu_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
      irq_is(1'b0);
      rchk(pstu_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
      conclude();
   end
endmodule : tb_top
